//--- hdl/dbp_port.sv
/*
 Serial port to a DSL bit pump carrying 2B1Q sign/magnitude bit pairs.
 Receive logic runs on the falling edge of the bit pump's bit clock and
 hands each pair to the system clock by toggle; transmit is launched from
 the system clock after a synchronised rising bit-clock edge.
 Assumes the system clock is far faster than the bit clock.
*/
`default_nettype none

module dbp_port (
    // System clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Link clocks and data from the bit pump
    input wire logic bit_clock_i,
    input wire logic symbol_align_clock_i,
    input wire logic line_rx_bit_i,
    input wire logic repeater_bit_clock_i,
    input wire logic repeater_align_clock_i,
    // Mode
    input wire logic repeater_mode_i,
    // Line output
    output logic line_tx_bit_o,
    // Transmit pair from the framer
    input wire logic tx_sign_i,
    input wire logic tx_mag_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic tx_underrun_o,
    // Receive pair to the framer
    output logic rx_sign_o,
    output logic rx_mag_o,
    output logic rx_valid_o,
    output logic rx_align_err_o
);
    import dbp_pkg::*;

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic have_sign;
        logic sign;
        logic word_sign;
        logic word_mag;
        logic toggle;
        logic err_toggle;
    } dbp_link_t;

    typedef struct packed {
        logic bclk_prev;
        logic aclk_last;
        logic rmode_prev;
        logic buf_full;
        logic buf_sign;
        logic buf_mag;
        logic pend_mag;
        dbp_phase_t phase;
        logic tx_bit;
        logic ready;
        logic underrun;
        logic rx_tog_prev;
        logic err_tog_prev;
        logic rx_sign;
        logic rx_mag;
        logic rx_valid;
        logic rx_err;
    } dbp_core_t;

    dbp_link_t lq;
    dbp_link_t ld;
    dbp_core_t q;
    dbp_core_t d;
    logic [DBP_SYNC_W-1:0] raw;
    logic [DBP_SYNC_W-1:0] s;
    logic sel_b;
    logic sel_a;

    // Link domain: receive pairs on the falling bit-clock edge
    always_comb begin
        ld = lq;
        ld.rst_meta = rstn_i;
        ld.rst_sync = lq.rst_meta;
        if (!lq.rst_sync) begin
            ld.have_sign = DBP_RST_BIT;
            ld.sign = DBP_RST_BIT;
            ld.word_sign = DBP_RST_BIT;
            ld.word_mag = DBP_RST_BIT;
            ld.toggle = DBP_RST_BIT;
            ld.err_toggle = DBP_RST_BIT;
        end else if (!symbol_align_clock_i) begin
            ld.sign = line_rx_bit_i;
            ld.have_sign = 1'h1;
            if (lq.have_sign) begin
                ld.err_toggle = ~lq.err_toggle;
            end
        end else begin
            if (lq.have_sign) begin
                ld.word_sign = lq.sign;
                ld.word_mag = line_rx_bit_i;
                ld.toggle = ~lq.toggle;
            end else begin
                ld.err_toggle = ~lq.err_toggle;
            end
            ld.have_sign = 1'h0;
        end
    end

    // Receive stays on the receive-side bit pump clock in every mode
    always_ff @(negedge bit_clock_i) begin
        lq <= ld;
    end

    // Link levels and receive toggles crossing into the system clock
    assign raw = {lq.err_toggle, repeater_mode_i, repeater_align_clock_i,
                  repeater_bit_clock_i, symbol_align_clock_i, bit_clock_i,
                  lq.toggle};

    dbp_sync #(
        .W(DBP_SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(raw),
        .q_o(s)
    );

    // Transmit clock pair selection
    always_comb begin
        sel_b = s[DBP_SI_BCLK];
        sel_a = s[DBP_SI_ACLK];
        if (s[DBP_SI_RMODE]) begin
            sel_b = s[DBP_SI_RBCLK];
            sel_a = s[DBP_SI_RACLK];
        end
    end

    // System domain: transmit launch and receive hand-over
    always_comb begin
        d = q;
        d.underrun = 1'h0;
        d.rx_valid = 1'h0;
        d.rx_err = 1'h0;
        d.bclk_prev = sel_b;
        d.rmode_prev = s[DBP_SI_RMODE];
        if (q.rmode_prev != s[DBP_SI_RMODE]) begin
            d.bclk_prev = DBP_RST_BIT;
            d.phase = DBP_PH_MAG;
            d.pend_mag = DBP_IDLE_BIT;
        end else if (q.bclk_prev && !sel_b) begin
            d.aclk_last = sel_a;
        end else if (!q.bclk_prev && sel_b) begin
            if (q.aclk_last) begin
                d.phase = DBP_PH_SIGN;
                if (q.buf_full) begin
                    d.tx_bit = q.buf_sign;
                    d.pend_mag = q.buf_mag;
                    d.buf_full = 1'h0;
                end else begin
                    d.tx_bit = DBP_IDLE_BIT;
                    d.pend_mag = DBP_IDLE_BIT;
                    d.underrun = 1'h1;
                end
            end else begin
                d.tx_bit = (q.phase == DBP_PH_SIGN) ? q.pend_mag : DBP_IDLE_BIT;
                d.phase = DBP_PH_MAG;
            end
        end
        // One-pair transmit buffer
        if (tx_valid_i && !q.buf_full) begin
            d.buf_sign = tx_sign_i;
            d.buf_mag = tx_mag_i;
            d.buf_full = 1'h1;
        end
        d.ready = ~d.buf_full;
        // Receive word stands two bit periods past its toggle
        d.rx_tog_prev = s[DBP_SI_RX_TOG];
        if (s[DBP_SI_RX_TOG] != q.rx_tog_prev) begin
            d.rx_sign = lq.word_sign;
            d.rx_mag = lq.word_mag;
            d.rx_valid = 1'h1;
        end
        d.err_tog_prev = s[DBP_SI_ERR_TOG];
        if (s[DBP_SI_ERR_TOG] != q.err_tog_prev) begin
            d.rx_err = 1'h1;
        end
        // Synchronous reset
        if (!rstn_i) begin
            d.bclk_prev = DBP_RST_BIT;
            d.aclk_last = DBP_RST_BIT;
            d.rmode_prev = DBP_RST_BIT;
            d.buf_full = DBP_RST_BIT;
            d.buf_sign = DBP_RST_BIT;
            d.buf_mag = DBP_RST_BIT;
            d.pend_mag = DBP_IDLE_BIT;
            d.phase = DBP_PH_MAG;
            d.tx_bit = DBP_IDLE_BIT;
            d.ready = DBP_RST_BIT;
            d.underrun = DBP_RST_BIT;
            d.rx_tog_prev = DBP_RST_BIT;
            d.err_tog_prev = DBP_RST_BIT;
            d.rx_sign = DBP_RST_BIT;
            d.rx_mag = DBP_RST_BIT;
            d.rx_valid = DBP_RST_BIT;
            d.rx_err = DBP_RST_BIT;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // Outputs
    assign line_tx_bit_o = q.tx_bit;
    assign tx_ready_o = q.ready;
    assign tx_underrun_o = q.underrun;
    assign rx_sign_o = q.rx_sign;
    assign rx_mag_o = q.rx_mag;
    assign rx_valid_o = q.rx_valid;
    assign rx_align_err_o = q.rx_err;
endmodule

`default_nettype wire

//--- hdl/dbp_sync.sv
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a level that holds for several destination clocks.
*/
`default_nettype none

module dbp_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } dbp_sync_st_t;

    dbp_sync_st_t q;
    dbp_sync_st_t d;

    always_comb begin
        d.meta = d_i;
        d.sync = q.meta;
        if (!rstn_i) begin
            d.meta = '0;
            d.sync = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    assign q_o = q.sync;
endmodule

`default_nettype wire

//--- shared/dbp_pkg.sv
/*
 Constants and types for the bit-pump serial port: sync vector layout,
 reset values and the transmit phase encoding.
 Assumes a single system clock and a bit-pump link clock outside it.
*/
// Operation
// - Transmit bit changes after each rising edge of the bit clock.
// - Receive bit is captured on each falling edge of the bit clock.
// - Alignment clock sampled on falling bit-clock edge: low sign, high magnitude.
// - Transmit sign goes out with alignment low, magnitude with it high.
// - Receive bit taken with alignment low is sign, with it high magnitude.
// - Repeater mode still times receive from the receive-side bit pump clocks.
`default_nettype none

package dbp_pkg;

    // Positions in the synchronised input vector
    localparam int unsigned DBP_SYNC_W = 7;
    localparam int unsigned DBP_SI_RX_TOG = 0;
    localparam int unsigned DBP_SI_BCLK = 1;
    localparam int unsigned DBP_SI_ACLK = 2;
    localparam int unsigned DBP_SI_RBCLK = 3;
    localparam int unsigned DBP_SI_RACLK = 4;
    localparam int unsigned DBP_SI_RMODE = 5;
    localparam int unsigned DBP_SI_ERR_TOG = 6;

    // Values after reset and idle line level
    localparam logic DBP_RST_BIT = 1'h0;
    localparam logic DBP_IDLE_BIT = 1'h0;
    localparam logic [DBP_SYNC_W-1:0] DBP_RST_SYNC = 7'h00;

    // Last bit sent on the transmit line
    typedef enum logic [1:0] {
        DBP_PH_SIGN = 2'h1,
        DBP_PH_MAG = 2'h2
    } dbp_phase_t;

endpackage

`default_nettype wire

//--- test/dbp_port_checker.sv
/*
 Pin assertions for the bit-pump port, bound into dbp_port.
 Assumes link clocks far slower than clk_i.
*/
`default_nettype none
module dbp_port_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Link side
    input wire logic bit_clock_i,
    input wire logic symbol_align_clock_i,
    input wire logic repeater_bit_clock_i,
    input wire logic repeater_mode_i,
    input wire logic line_tx_bit_o,
    // Framer side
    input wire logic tx_valid_i,
    input wire logic tx_ready_o,
    input wire logic tx_underrun_o,
    input wire logic rx_sign_o,
    input wire logic rx_mag_o,
    input wire logic rx_valid_o,
    input wire logic rx_align_err_o
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic sel = repeater_mode_i ? repeater_bit_clock_i : bit_clock_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_tx_launch: assert property (
        $changed(line_tx_bit_o) |-> $past(sel, 2) || $past(sel, 3)) else $error("tx off rise");
    a_ready_drop: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
        else $error("ready after take");
    a_urun_pulse: assert property (tx_underrun_o |=> !tx_underrun_o)
        else $error("underrun long");
    a_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("rx valid long");
    a_rx_hold: assert property (!rx_valid_o |-> $stable({rx_sign_o, rx_mag_o}))
        else $error("rx pair moved");
    a_rx_edge: assert property (
        rx_valid_o |-> !$past(bit_clock_i) && !$past(bit_clock_i, 2)) else $error("rx off fall");
    a_rx_align: assert property (rx_valid_o |-> $past(symbol_align_clock_i, 2))
        else $error("rx pair not on magnitude");
    a_err_pulse: assert property (rx_align_err_o |=> !rx_align_err_o)
        else $error("align error long");
    c_take: cover property (tx_valid_i && tx_ready_o);
    c_rx: cover property (rx_valid_o);
    c_urun: cover property (tx_underrun_o);
endmodule
bind dbp_port dbp_port_checker chk (.*);
`default_nettype wire

//--- test/dbp_pump_model.sv
/*
 Bit-pump model: free-running bit and alignment clocks, receive bits,
 and a record of transmit pairs seen on the line.
 Assumes the line bit settles within one bit period of a rise.
*/
`default_nettype none
module dbp_pump_model #(
    parameter realtime PH = 1.0
) (
    // Line
    input wire logic tx_i,
    // Clocks and receive bit
    output logic bclk_o,
    output logic aclk_o,
    output logic rx_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] q[$];
    logic [1:0] rxp = 2'h0;
    logic [1:0] n = 2'h0;
    logic s = 1'b0;
    logic slip = 1'b0;
    initial begin
        {bclk_o, aclk_o, rx_o} = 3'h0;
        #(PH);
        forever begin
            #15;
            if (aclk_o) q.push_back({s, tx_i});
            else s = tx_i;
            if (slip) slip = 1'b0;
            else aclk_o = ~aclk_o;
            rx_o = aclk_o ? n[0] : n[1];
            bclk_o = 1'b1;
            #15;
            bclk_o = 1'b0;
            if (aclk_o) begin
                rxp = n;
                n = n + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/test_dbp_port.sv
/*
 Bench for dbp_port with a main and a repeater pump model.
 Assumes the checker binds itself from its own file.
*/
`default_nettype none
module test_dbp_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic repeater_mode_i = 1'b0;
    logic tx_sign_i = 1'b0;
    logic tx_mag_i = 1'b0;
    logic tx_valid_i = 1'b0;
    wire logic bit_clock_i, symbol_align_clock_i, line_rx_bit_i, line_tx_bit_o;
    wire logic repeater_bit_clock_i, repeater_align_clock_i, tx_ready_o, tx_underrun_o;
    wire logic rx_sign_o, rx_mag_o, rx_valid_o, rx_align_err_o;
    int n_fail = 0;
    int compares = 0;
    always #2.5 clk_i = ~clk_i;
    dbp_pump_model #(.PH(1.3)) m (.tx_i(line_tx_bit_o), .bclk_o(bit_clock_i),
        .aclk_o(symbol_align_clock_i), .rx_o(line_rx_bit_i));
    dbp_pump_model #(.PH(8.7)) r (.tx_i(line_tx_bit_o), .bclk_o(repeater_bit_clock_i),
        .aclk_o(repeater_align_clock_i), .rx_o());
    dbp_port dut (.*);
    task automatic summarize();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hit(input logic f);
        if (f !== 1'b1) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic send(input logic [1:0] p);
        @(negedge clk_i);
        for (int i = 0; i < 400 && tx_ready_o !== 1'b1; i++) @(negedge clk_i);
        hit(tx_ready_o);
        @(posedge clk_i);
        {tx_sign_i, tx_mag_i, tx_valid_i} <= {p, 1'b1};
        @(posedge clk_i);
        tx_valid_i <= 1'b0;
    endtask
    task automatic tx_test(input logic rep);
        logic [1:0] q[$];
        m.q.delete();
        r.q.delete();
        for (int k = 0; k < 4; k++) send(2'h3 - k[1:0]);
        for (int i = 0; i < 400 && tx_underrun_o !== 1'b1; i++) @(negedge clk_i);
        hit(tx_underrun_o);
        for (int i = 0; i < 400 && (rep ? r.q.size() : m.q.size()) < 8; i++) @(negedge clk_i);
        if (rep) q = r.q;
        else q = m.q;
        while (q.size() > 1 && q[0] === 2'h0) void'(q.pop_front());
        for (int k = 0; k < 5; k++) cmp(q[k], k < 4 ? 2'h3 - k[1:0] : 2'h0);
    endtask
    task automatic rx_test();
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_i);
            for (int i = 0; i < 400 && rx_valid_o !== 1'b1; i++) @(negedge clk_i);
            hit(rx_valid_o);
            cmp({rx_sign_o, rx_mag_o}, m.rxp);
        end
    endtask
    task automatic err_test();
        m.slip = 1'b1;
        for (int i = 0; i < 400 && rx_align_err_o !== 1'b1; i++) @(negedge clk_i);
        hit(rx_align_err_o);
        cmp({rx_valid_o, rx_align_err_o}, 2'h1);
    endtask
    initial begin
        repeat (19) @(posedge clk_i);
        @(negedge clk_i);
        cmp({tx_ready_o, rx_valid_o}, 2'h0);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        @(negedge clk_i);
        @(negedge clk_i);
        cmp({tx_ready_o, tx_underrun_o}, 2'h2);
        rx_test();
        err_test();
        tx_test(1'b0);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeater_mode_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        rx_test();
        tx_test(1'b1);
        summarize();
    end
endmodule
`default_nettype wire
